/* File: rtl/pplc_defs.vh */
// Constants of the port link power control block: register offsets,
// field positions, reset values and timing figures.
// Assumes a 100 MHz core clock and a six-port switch, port 0 upstream.
`ifndef PPLC_DEFS_VH
`define PPLC_DEFS_VH

// Port count and timer field width
`define PPLC_NPORT 6
`define PPLC_TMR_W 12

// Register byte offsets on APB
`define PPLC_OFF_LINK_CTL 8'h00
`define PPLC_OFF_PM_PRIV 8'h04
`define PPLC_OFF_LINK_CTL2 8'h08
`define PPLC_OFF_LINK_STS2 8'h0C
`define PPLC_OFF_SER_CTL 8'h10
`define PPLC_OFF_PHY_CFG 8'h14
`define PPLC_OFF_PWR_STS 8'h18

// Field positions
`define PPLC_F_L1_EN 8
`define PPLC_F_DEEP_LSB 16
`define PPLC_F_CMPL_LSB 8
`define PPLC_F_VALID_LSB 8
`define PPLC_F_L1_REQ 8
`define PPLC_F_L1_IN 9

// Reset values
`define PPLC_RST_LINK_CTL 32'h0000_0000
`define PPLC_RST_PM_PRIV 32'h0040_0010
`define PPLC_RST_L0S_EN 6'h00
`define PPLC_RST_SHALLOW_IDLE_ENTRY_TIMER 12'h010
`define PPLC_RST_DEEP_IDLE_ENTRY_TIMER 12'h040
`define PPLC_RST_XLDIS 6'h3F
`define PPLC_RST_SDE 6'h3F
`define PPLC_RST_CMPL 6'h3F
`define PPLC_RST_LSE 6'h00
`define PPLC_XLINK_MODE 3'h4

// Timing figures: times in ms, clock in kHz
`define PPLC_CLK_KHZ 100000
`define PPLC_ACT_HOLD_MS 200
`define PPLC_IND_UPD_MS 40

`endif

/* File: rtl/pplc_hold_timer.v */
// Entry timer: flags when a condition has held without a break for
// more than a programmed number of clock cycles.
// Assumes cond and en are synchronous to pclk.
`timescale 1ns/1ps
`default_nettype none
`include "pplc_defs.vh"

module pplc_hold_timer (
  // Clock and reset
  input wire pclk,
  input wire presetn,
  // Control
  input wire en,
  input wire cond,
  input wire [`PPLC_TMR_W-1:0] limit,
  // Result
  output reg expired_ff
);

  // Cycles the condition has held so far
  reg [`PPLC_TMR_W-1:0] cnt_ff;

  // Any break in the condition restarts the count from zero
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cnt_ff <= {`PPLC_TMR_W{1'b0}};
      expired_ff <= 1'b0;
    end
    else if (!en || !cond)
    begin
      // Disabled or condition broken
      cnt_ff <= {`PPLC_TMR_W{1'b0}};
      expired_ff <= 1'b0;
    end
    else if (cnt_ff >= limit)
    begin
      // Held long enough; stays set while the condition holds
      expired_ff <= 1'b1;
    end
    else
    begin
      cnt_ff <= cnt_ff + {{(`PPLC_TMR_W-1){1'b0}}, 1'b1};
    end
  end

endmodule
`default_nettype wire

/* File: rtl/pplc_top.v */
// Port link power control for a six-port switch: ASPM entry, status
// indicators, de-emphasis choice, low-swing and crosslink control.
// Assumes port 0 is upstream, LTSSM status inputs synchronous to pclk.
// What this block does
// - ASPM enable lets hardware start transitions itself
// - L0s timer sets required condition hold time
// - Upstream L0s needs active downstream receivers L0s
// - Upstream L0s needs no TLP or no credits
// - Upstream L0s needs no pending DLLP
// - Downstream L0s needs upstream receivers in L0s
// - Downstream L0s needs idle TLP and DLLP
// - L1 timer expiry in L0/L0s requests L1
// - Only upstream port requests L1
// - Ack enters L1, nak falls to L0s
// - Upstream L1 needs active downstream ports L1
// - Link-up indicator follows data link layer state
// - Activity indicator on non-vendor TLP traffic
// - Activity held 200 ms, retriggered by traffic
// - Indicators refreshed once per 40 ms period
// - Gen1 uses -3.5dB; Gen2 uses selectable field
// - One de-emphasis setting for whole link
// - De-emphasis chosen in Recovery, upstream component decides
// - Upstream port advertises field, adopts partner decision
// - Downstream ports ignore partner, use own field
// - Low swing forces de-emphasis off, status invalid
// - Crosslink disable resets 1 except mode 4
//
// Chosen here: the placing of the registers and register access over APB.
`timescale 1ns/1ps
`default_nettype none
`include "pplc_defs.vh"

module pplc_top #(
  parameter ACT_HOLD_CYC = `PPLC_ACT_HOLD_MS * `PPLC_CLK_KHZ,
  parameter IND_UPD_CYC = `PPLC_IND_UPD_MS * `PPLC_CLK_KHZ
) (
  // Clock and reset
  input wire pclk,
  input wire presetn,
  // APB slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata_ff,
  output reg pready_ff,
  output reg pslverr_ff,
  // Strap
  input wire [2:0] switch_operating_mode,
  // Per-port link status from the LTSSM and data link layer
  input wire [5:0] port_dl_up,
  input wire [5:0] port_dev_d3,
  input wire [5:0] port_rx_l0s,
  input wire [5:0] port_in_l1,
  input wire [5:0] port_in_l0_l0s,
  input wire [5:0] port_in_recovery,
  input wire [5:0] port_in_compliance,
  input wire [5:0] port_rate_5g,
  // Per-port transmit backlog and traffic
  input wire [5:0] port_tlp_pend,
  input wire [5:0] port_fc_none,
  input wire [5:0] port_dllp_pend,
  input wire [5:0] port_tlp_seen,
  // Upstream partner answers and decisions
  input wire up_l1_ack,
  input wire up_l1_nak,
  input wire up_partner_deemph_6db,
  // Link power requests
  output reg [5:0] port_l0s_req_ff,
  output reg up_l1_req_ff,
  output reg up_l1_enter_ff,
  output reg up_l0s_fallback_ff,
  // Indicators, active low
  output reg [5:0] port_link_up_indicator_n_ff,
  output reg [5:0] port_activity_indicator_n_ff,
  // Transmitter control
  output reg [5:0] tx_deemph_6db_ff,
  output reg [5:0] tx_deemph_off_ff,
  output reg [5:0] tx_low_swing_ff,
  output reg up_adv_deemph_6db_ff,
  output reg [5:0] crosslink_en_ff
);

  // L1 request sequencer states
  localparam [1:0] L1_IDLE = 2'b00;
  localparam [1:0] L1_REQ = 2'b01;
  localparam [1:0] L1_HOLD = 2'b10;

  // Reload values of the long counters, cut to the counter widths
  localparam integer ACT_LOAD_I = ACT_HOLD_CYC - 1;
  localparam integer UPD_LOAD_I = IND_UPD_CYC - 1;
  localparam [24:0] ACT_LOAD = ACT_LOAD_I[24:0];
  localparam [21:0] UPD_LOAD = UPD_LOAD_I[21:0];

  // True when each downstream port is parked, down or ready
  function ds_all;
    input [5:0] parked;
    input [5:0] up;
    input [5:0] ready;
    integer k;
    begin
      ds_all = 1'b1;
      for (k = 1; k < `PPLC_NPORT; k = k + 1)
        if (!(parked[k] || !up[k] || ready[k]))
          ds_all = 1'b0;
    end
  endfunction

  // Software-visible registers and the strap-done flag
  reg [5:0] l0s_en_ff;
  reg l1_en_ff;
  reg [`PPLC_TMR_W-1:0] shallow_idle_entry_timer_ff;
  reg [`PPLC_TMR_W-1:0] deep_idle_entry_timer_ff;
  reg [5:0] selectable_deemph_field_ff;
  reg [5:0] cmpl_deemph_ff;
  reg [5:0] low_swing_on_bit_ff;
  reg [5:0] cross_connection_disable_bit_ff;
  reg strap_done_ff;

  // Link power state
  reg [1:0] l1_state_ff;
  reg [1:0] nxt_l1_state;
  reg [21:0] upd_cnt_ff;
  wire upd_tick;
  wire [5:0] l0s_cond;
  wire [5:0] l0s_expired;
  wire l1_cond;
  wire l1_expired;
  wire [5:0] tx_idle;
  wire [5:0] port_active;

  // APB decode
  wire setup = psel && !penable;
  wire wr_en = psel && penable && pready_ff && pwrite;
  reg [31:0] rd_mux;
  reg rd_hit;

  // Transmit side idle: no TLP or no credits, and no DLLP
  assign tx_idle = (~port_tlp_pend | port_fc_none) & ~port_dllp_pend;

  // Upstream L0s waits for active downstream receivers
  assign l0s_cond[0] = tx_idle[0] &&
    ds_all(port_dev_d3, port_dl_up, port_rx_l0s);

  // Downstream L0s waits for the upstream receivers
  genvar g;
  generate
    for (g = 1; g < `PPLC_NPORT; g = g + 1)
    begin : g_ds_cond
      assign l0s_cond[g] = tx_idle[g] && port_rx_l0s[0];
    end
  endgenerate

  // One entry timer per port; L0s enable gates it
  generate
    for (g = 0; g < `PPLC_NPORT; g = g + 1)
    begin : g_l0s
      pplc_hold_timer u_l0s_tmr (
        .pclk(pclk),
        .presetn(presetn),
        .en(l0s_en_ff[g]),
        .cond(l0s_cond[g]),
        .limit(shallow_idle_entry_timer_ff),
        .expired_ff(l0s_expired[g])
      );
    end
  endgenerate

  // L1 only considered on the upstream port
  assign l1_cond = tx_idle[0] &&
    ds_all(port_dev_d3, port_dl_up, port_in_l1);

  pplc_hold_timer u_l1_tmr (
    .pclk(pclk),
    .presetn(presetn),
    .en(l1_en_ff),
    .cond(l1_cond),
    .limit(deep_idle_entry_timer_ff),
    .expired_ff(l1_expired)
  );

  // L1 sequencer: request, then wait for the partner's answer
  always @*
  begin
    nxt_l1_state = l1_state_ff;
    case (l1_state_ff)
      L1_IDLE:
        if (l1_expired && port_in_l0_l0s[0])
          nxt_l1_state = L1_REQ;
      L1_REQ:
        if (up_l1_ack || up_l1_nak)
          nxt_l1_state = L1_HOLD;
      L1_HOLD:
        // Re-arm only after the conditions break, so no request storm
        if (!l1_expired)
          nxt_l1_state = L1_IDLE;
      default:
        nxt_l1_state = L1_IDLE;
    endcase
  end

  // Sequencer registers and request outputs
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      l1_state_ff <= L1_IDLE;
      up_l1_req_ff <= 1'b0;
      up_l1_enter_ff <= 1'b0;
      up_l0s_fallback_ff <= 1'b0;
      port_l0s_req_ff <= 6'h00;
    end
    else
    begin
      l1_state_ff <= nxt_l1_state;
      up_l1_req_ff <= (nxt_l1_state == L1_REQ);
      // Acknowledge wins if both arrive together
      up_l1_enter_ff <= (l1_state_ff == L1_REQ) && up_l1_ack;
      up_l0s_fallback_ff <= (l1_state_ff == L1_REQ) && !up_l1_ack &&
        up_l1_nak;
      port_l0s_req_ff <= l0s_expired;
    end
  end

  // Shared indicator refresh period
  assign upd_tick = (upd_cnt_ff == 22'h00_0000);

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      upd_cnt_ff <= 22'h00_0000;
    else if (upd_tick)
      upd_cnt_ff <= UPD_LOAD;
    else
      upd_cnt_ff <= upd_cnt_ff - 22'h00_0001;
  end

  // Per-port activity stretch and indicator refresh
  generate
    for (g = 0; g < `PPLC_NPORT; g = g + 1)
    begin : g_ind
      reg [24:0] act_cnt_ff;
      // Each new TLP reloads the full hold time
      always @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
          act_cnt_ff <= 25'h000_0000;
        else if (port_tlp_seen[g])
          act_cnt_ff <= ACT_LOAD;
        else if (act_cnt_ff != 25'h000_0000)
          act_cnt_ff <= act_cnt_ff - 25'h000_0001;
      end
      assign port_active[g] = port_tlp_seen[g] || (act_cnt_ff != 25'h000_0000);
      // Outputs change only on the refresh tick, like the expander pins
      always @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
        begin
          port_link_up_indicator_n_ff[g] <= 1'b1;
          port_activity_indicator_n_ff[g] <= 1'b1;
        end
        else if (upd_tick)
        begin
          port_link_up_indicator_n_ff[g] <= !port_dl_up[g];
          port_activity_indicator_n_ff[g] <= !port_active[g];
        end
      end
    end
  endgenerate

  // De-emphasis per port; one value drives all lanes of the link
  generate
    for (g = 0; g < `PPLC_NPORT; g = g + 1)
    begin : g_deemph
      // Field value 1 selects -3.5dB, 0 selects -6.0dB
      wire pick_6db = (g == 0) ? up_partner_deemph_6db :
        !selectable_deemph_field_ff[g];
      always @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
        begin
          tx_deemph_6db_ff[g] <= 1'b0;
          tx_deemph_off_ff[g] <= 1'b0;
          tx_low_swing_ff[g] <= 1'b0;
        end
        else
        begin
          tx_low_swing_ff[g] <= low_swing_on_bit_ff[g];
          tx_deemph_off_ff[g] <= low_swing_on_bit_ff[g];
          if (low_swing_on_bit_ff[g] || !port_rate_5g[g])
            tx_deemph_6db_ff[g] <= 1'b0;
          else if (port_in_compliance[g])
            tx_deemph_6db_ff[g] <= !cmpl_deemph_ff[g];
          else if (port_in_recovery[g])
            tx_deemph_6db_ff[g] <= pick_6db;
        end
      end
    end
  endgenerate

  // Upstream advertisement and crosslink enable
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      up_adv_deemph_6db_ff <= 1'b0;
      crosslink_en_ff <= 6'h00;
    end
    else
    begin
      up_adv_deemph_6db_ff <= !selectable_deemph_field_ff[0];
      crosslink_en_ff <= ~cross_connection_disable_bit_ff;
    end
  end

  // Register read mux; unmapped offsets read zero with an error
  always @*
  begin
    rd_mux = 32'h0000_0000;
    rd_hit = 1'b1;
    case (paddr)
      `PPLC_OFF_LINK_CTL:
      begin
        rd_mux[5:0] = l0s_en_ff;
        rd_mux[`PPLC_F_L1_EN] = l1_en_ff;
      end
      `PPLC_OFF_PM_PRIV:
      begin
        rd_mux[`PPLC_TMR_W-1:0] = shallow_idle_entry_timer_ff;
        rd_mux[`PPLC_F_DEEP_LSB +: `PPLC_TMR_W] = deep_idle_entry_timer_ff;
      end
      `PPLC_OFF_LINK_CTL2:
      begin
        rd_mux[5:0] = selectable_deemph_field_ff;
        rd_mux[`PPLC_F_CMPL_LSB +: 6] = cmpl_deemph_ff;
      end
      `PPLC_OFF_LINK_STS2:
      begin
        // Current value invalid while low swing is on
        rd_mux[5:0] = ~tx_deemph_6db_ff & ~low_swing_on_bit_ff;
        rd_mux[`PPLC_F_VALID_LSB +: 6] = ~low_swing_on_bit_ff;
      end
      `PPLC_OFF_SER_CTL:
        rd_mux[5:0] = low_swing_on_bit_ff;
      `PPLC_OFF_PHY_CFG:
        rd_mux[5:0] = cross_connection_disable_bit_ff;
      `PPLC_OFF_PWR_STS:
      begin
        rd_mux[5:0] = port_l0s_req_ff;
        rd_mux[`PPLC_F_L1_REQ] = up_l1_req_ff;
        rd_mux[`PPLC_F_L1_IN] = port_in_l1[0];
      end
      default:
        rd_hit = 1'b0;
    endcase
  end

  // APB answer: no wait state, ready raised in the first cycle of the access phase
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready_ff <= 1'b0;
      prdata_ff <= 32'h0000_0000;
      pslverr_ff <= 1'b0;
    end
    else
    begin
      pready_ff <= setup;
      prdata_ff <= (setup && !pwrite) ? rd_mux : 32'h0000_0000;
      pslverr_ff <= setup && !rd_hit;
    end
  end

  // Register writes, taken in the access cycle with ready high
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      l0s_en_ff <= `PPLC_RST_L0S_EN;
      l1_en_ff <= 1'b0;
      shallow_idle_entry_timer_ff <= `PPLC_RST_SHALLOW_IDLE_ENTRY_TIMER;
      deep_idle_entry_timer_ff <= `PPLC_RST_DEEP_IDLE_ENTRY_TIMER;
      selectable_deemph_field_ff <= `PPLC_RST_SDE;
      cmpl_deemph_ff <= `PPLC_RST_CMPL;
      low_swing_on_bit_ff <= `PPLC_RST_LSE;
      cross_connection_disable_bit_ff <= `PPLC_RST_XLDIS;
      strap_done_ff <= 1'b0;
    end
    else
    begin
      // Mode strap sampled once, in the first cycle after release
      if (!strap_done_ff)
      begin
        strap_done_ff <= 1'b1;
        cross_connection_disable_bit_ff <=
          (switch_operating_mode == `PPLC_XLINK_MODE) ? 6'h00 : `PPLC_RST_XLDIS;
      end
      else if (wr_en && paddr == `PPLC_OFF_PHY_CFG)
        cross_connection_disable_bit_ff <= pwdata[5:0];
      if (wr_en)
      begin
        case (paddr)
          `PPLC_OFF_LINK_CTL:
          begin
            l0s_en_ff <= pwdata[5:0];
            l1_en_ff <= pwdata[`PPLC_F_L1_EN];
          end
          `PPLC_OFF_PM_PRIV:
          begin
            shallow_idle_entry_timer_ff <= pwdata[`PPLC_TMR_W-1:0];
            deep_idle_entry_timer_ff <= pwdata[`PPLC_F_DEEP_LSB +: `PPLC_TMR_W];
          end
          `PPLC_OFF_LINK_CTL2:
          begin
            selectable_deemph_field_ff <= pwdata[5:0];
            cmpl_deemph_ff <= pwdata[`PPLC_F_CMPL_LSB +: 6];
          end
          `PPLC_OFF_SER_CTL:
            low_swing_on_bit_ff <= pwdata[5:0];
          default:
            l1_en_ff <= l1_en_ff;
        endcase
      end
    end
  end

endmodule
`default_nettype wire

/* File: sim/pplc_partner.sv */
// Upstream link partner model: answers the L1 request, decides de-emphasis.
// Assumes the bench sets the answer delay and whether it accepts.
`timescale 1ns/1ps
`default_nettype none

module pplc_partner (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Request and knobs
  input wire logic l1_req,
  input wire logic accept,
  input wire logic [3:0] lag,
  input wire logic decide_6db,
  // Answers
  output logic ack,
  output logic nak,
  output logic deemph_6db
);
  logic [3:0] wait_ff; // Cycles the request has waited
  logic done_ff; // One answer per request, no repeats
  // Upstream component decides one value for all lanes
  assign deemph_6db = decide_6db;
  // Answer once after the lag, then wait for the request to drop
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      wait_ff <= 4'h0;
      done_ff <= 1'b0;
      ack <= 1'b0;
      nak <= 1'b0;
    end
    else
    begin
      ack <= 1'b0;
      nak <= 1'b0;
      if (!l1_req)
      begin
        wait_ff <= 4'h0;
        done_ff <= 1'b0;
      end
      else if (!done_ff && wait_ff == lag)
      begin
        ack <= accept;
        nak <= !accept;
        done_ff <= 1'b1;
      end
      else if (!done_ff)
        wait_ff <= wait_ff + 4'h1;
    end
  end
endmodule
`default_nettype wire

/* File: sim/pplc_checker.sv */
// Checker for the port link power control block.
// Assumes one clock; bound to the top, sees its ports only.
`timescale 1ns/1ps
`default_nettype none

module pplc_checker #(
  parameter ACT_HOLD_CYC = 50
) (
  // Clock and reset
  input wire pclk,
  input wire presetn,
  // APB
  input wire psel,
  input wire penable,
  input wire pready_ff,
  input wire pslverr_ff,
  // Link status and traffic
  input wire [5:0] port_dl_up,
  input wire [5:0] port_dev_d3,
  input wire [5:0] port_rx_l0s,
  input wire [5:0] port_in_l1,
  input wire [5:0] port_dllp_pend,
  input wire [5:0] port_rate_5g,
  input wire [5:0] port_tlp_seen,
  input wire up_l1_ack,
  input wire up_l1_nak,
  // Outputs watched
  input wire [5:0] port_l0s_req_ff,
  input wire up_l1_req_ff,
  input wire up_l1_enter_ff,
  input wire up_l0s_fallback_ff,
  input wire [5:0] port_link_up_indicator_n_ff,
  input wire [5:0] port_activity_indicator_n_ff,
  input wire [5:0] tx_deemph_6db_ff,
  input wire [5:0] tx_deemph_off_ff,
  input wire [5:0] tx_low_swing_ff
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  int unsigned quiet_ff; // Cycles since traffic on port 2
  wire ds1_parked = port_dev_d3[1] | ~port_dl_up[1] | port_in_l1[1]; // Port 1 allows L1
  // Saturating so a long idle run cannot wrap
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      quiet_ff <= 0;
    else if (port_tlp_seen[2])
      quiet_ff <= 0;
    else if (quiet_ff < ACT_HOLD_CYC + 2)
      quiet_ff <= quiet_ff + 1;
  end
  a_ready_pulse: assert property (psel && !penable |=> pready_ff)
    else $error("no ready after setup");
  a_err_ready: assert property (pslverr_ff |-> pready_ff)
    else $error("error without ready");
  a_l1_ack: assert property (up_l1_req_ff && up_l1_ack |-> ##[1:2] up_l1_enter_ff)
    else $error("ack did not enter L1");
  a_l1_nak: assert property (up_l1_req_ff && up_l1_nak && !up_l1_ack
    |-> ##[1:2] up_l0s_fallback_ff)
    else $error("nak did not fall back");
  a_l1_cause: assert property ($rose(up_l1_req_ff) |-> $past(ds1_parked, 3))
    else $error("L1 asked with active port");
  a_up_dllp: assert property (port_dllp_pend[0] [*3] |=> !port_l0s_req_ff[0])
    else $error("upstream L0s with DLLP pending");
  a_ds_rx: assert property (!port_rx_l0s[0] [*3] |=> !port_l0s_req_ff[1])
    else $error("downstream L0s while upstream rx active");
  a_up_ds: assert property ((!ds1_parked && !port_dev_d3[1] && !port_rx_l0s[1]) [*3]
    |=> !port_l0s_req_ff[0])
    else $error("upstream L0s with active downstream");
  a_link_up: assert property ($rose(port_link_up_indicator_n_ff[1])
    |-> !$past(port_dl_up[1]) || !$past(port_dl_up[1], 2))
    else $error("link up negated while up");
  a_act_hold: assert property ($rose(port_activity_indicator_n_ff[2])
    |-> quiet_ff >= ACT_HOLD_CYC - 2)
    else $error("activity dropped early");
  a_low_swing: assert property (tx_low_swing_ff[1] [*2]
    |-> tx_deemph_off_ff[1] && !tx_deemph_6db_ff[1])
    else $error("de-emphasis on in low swing");
  a_gen1_deemph: assert property (!port_rate_5g[1] [*2] |-> !tx_deemph_6db_ff[1])
    else $error("gen1 port at -6dB");
  c_enter: cover property (up_l1_enter_ff);
  c_fallback: cover property (up_l0s_fallback_ff);
  c_slverr: cover property (pslverr_ff);
endmodule
`default_nettype wire

/* File: sim/pplc_top_bench.sv */
// Bench for the port link power control block: registers, ASPM entry,
// indicators, de-emphasis, low swing, crosslink.
// Assumes the partner model and shortened indicator counts.
`timescale 1ns/1ps
`default_nettype none
`include "pplc_defs.vh"

module pplc_top_bench;
  localparam int ACT = 50; // Activity hold, cycles
  localparam int UPD = 10; // Indicator refresh, cycles
  logic pclk, presetn, psel, penable, pwrite, e, accept, dec6;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata_ff, q;
  logic pready_ff, pslverr_ff, up_l1_ack, up_l1_nak, up_partner_deemph_6db;
  logic [2:0] switch_operating_mode;
  logic [5:0] port_dl_up, port_dev_d3, port_rx_l0s, port_in_l1, port_in_l0_l0s;
  logic [5:0] port_in_recovery, port_in_compliance, port_rate_5g, port_tlp_pend;
  logic [5:0] port_fc_none, port_dllp_pend, port_tlp_seen, port_l0s_req_ff;
  logic [5:0] port_link_up_indicator_n_ff, port_activity_indicator_n_ff;
  logic [5:0] tx_deemph_6db_ff, tx_deemph_off_ff, tx_low_swing_ff, crosslink_en_ff;
  logic up_l1_req_ff, up_l1_enter_ff, up_l0s_fallback_ff, up_adv_deemph_6db_ff;
  logic [3:0] lag;
  int n_fail, n_checks, n;

  pplc_top #(.ACT_HOLD_CYC(ACT), .IND_UPD_CYC(UPD)) u_pplc_top (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata_ff,
    .pready_ff, .pslverr_ff, .switch_operating_mode, .port_dl_up, .port_dev_d3,
    .port_rx_l0s, .port_in_l1, .port_in_l0_l0s, .port_in_recovery, .port_in_compliance,
    .port_rate_5g, .port_tlp_pend, .port_fc_none, .port_dllp_pend, .port_tlp_seen,
    .up_l1_ack, .up_l1_nak, .up_partner_deemph_6db, .port_l0s_req_ff, .up_l1_req_ff,
    .up_l1_enter_ff, .up_l0s_fallback_ff, .port_link_up_indicator_n_ff,
    .port_activity_indicator_n_ff, .tx_deemph_6db_ff, .tx_deemph_off_ff,
    .tx_low_swing_ff, .up_adv_deemph_6db_ff, .crosslink_en_ff);
  pplc_partner u_pplc_partner (.pclk, .presetn, .l1_req(up_l1_req_ff), .accept, .lag,
    .decide_6db(dec6), .ack(up_l1_ack), .nak(up_l1_nak), .deemph_6db(up_partner_deemph_6db));

  // Free running core clock
  initial
  begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  // Count a comparison, report a mismatch at once
  task chk(input logic [31:0] got, input logic [31:0] x);
  begin
    n_checks++;
    if (got !== x)
    begin
      n_fail++;
      $display("Error at %0t: got %0h expected %0h", $time, got, x);
    end
  end
  endtask
  task stop_test;
  begin
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  end
  endtask
  task tmo;
  begin
    n_fail++;
    $display("Error at %0t: wait timed out", $time);
    stop_test();
  end
  endtask
  // One APB transfer; holds the request until ready is sampled high
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
  begin
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (k = 0; k < 20; k++)
    begin
      @(posedge pclk);
      if (pready_ff === 1'b1)
        break;
    end
    q = prdata_ff;
    e = pslverr_ff;
    if (k == 20)
      tmo();
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  end
  endtask
  task rd(input logic [7:0] a, input logic [31:0] x);
  begin
    apb(1'b0, a, 32'h0);
    chk(q, x);
  end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
  begin
    apb(1'b1, a, d);
  end
  endtask
  // Wait for the L1 answer pulse and compare enter and fallback
  task l1_wait(input logic [1:0] x);
    int k;
  begin
    for (k = 0; k < 100; k++)
    begin
      @(posedge pclk);
      if (up_l1_enter_ff === 1'b1 || up_l0s_fallback_ff === 1'b1)
        break;
    end
    if (k == 100)
      tmo();
    chk({up_l1_enter_ff, up_l0s_fallback_ff}, x);
  end
  endtask
  // Short Recovery visit on ports 0 to 2 with a partner decision
  task recov(input logic d);
  begin
    dec6 <= d;
    port_in_recovery <= 6'h07;
    repeat (2) @(posedge pclk);
    port_in_recovery <= 6'h00;
    repeat (2) @(posedge pclk);
  end
  endtask

  // Main sequence
  initial
  begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {switch_operating_mode, port_dev_d3, port_in_l1, port_in_recovery} = '0;
    {port_in_compliance, port_rate_5g, port_tlp_pend, port_fc_none} = '0;
    {port_dllp_pend, port_tlp_seen, port_rx_l0s, port_in_l0_l0s} = '0;
    {accept, dec6, lag} = '0;
    port_dl_up = 6'h03;
    presetn = 1'b0;
    n_fail = 0;
    n_checks = 0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(`PPLC_OFF_LINK_CTL, `PPLC_RST_LINK_CTL);
    rd(`PPLC_OFF_PM_PRIV, `PPLC_RST_PM_PRIV);
    rd(`PPLC_OFF_LINK_CTL2, 32'h0000_3F3F);
    rd(`PPLC_OFF_PHY_CFG, 32'h0000_003F);
    chk(crosslink_en_ff, 6'h00);
    rd(8'h1C, 32'h0000_0000);
    chk(e, 1'b1);
    wr(`PPLC_OFF_PHY_CFG, 32'h0000_003E);
    // Enable follows the disable bit one edge after the write lands
    @(posedge pclk);
    chk(crosslink_en_ff, 6'h01);
    chk(port_link_up_indicator_n_ff, 6'h3C);
    chk(port_activity_indicator_n_ff, 6'h3F);
    $display("register test done");
    wr(`PPLC_OFF_LINK_CTL, 32'h0000_003F);
    wr(`PPLC_OFF_PM_PRIV, 32'h0008_0004);
    port_rx_l0s <= 6'h01;
    for (n = 0; n < 60 && port_l0s_req_ff[1] !== 1'b1; n++)
      @(posedge pclk);
    chk(n >= 5 && n <= 8, 1'b1);
    port_dllp_pend <= 6'h03;
    repeat (4) @(posedge pclk);
    chk(port_l0s_req_ff[1], 1'b0);
    port_dllp_pend <= 6'h00;
    repeat (40) @(posedge pclk);
    chk(port_l0s_req_ff[0], 1'b0);
    port_dev_d3 <= 6'h02;
    port_tlp_pend <= 6'h01;
    port_fc_none <= 6'h01;
    repeat (12) @(posedge pclk);
    chk(port_l0s_req_ff[0], 1'b1);
    port_fc_none <= 6'h00;
    repeat (4) @(posedge pclk);
    chk(port_l0s_req_ff[0], 1'b0);
    port_dev_d3 <= 6'h00;
    port_tlp_pend <= 6'h00;
    $display("L0s test done");
    port_in_l0_l0s <= 6'h01;
    lag <= 4'h3;
    accept <= 1'b1;
    wr(`PPLC_OFF_LINK_CTL, 32'h0000_013F);
    repeat (30) @(posedge pclk);
    chk(up_l1_req_ff, 1'b0);
    port_in_l1 <= 6'h02;
    l1_wait(2'b10);
    port_in_l1 <= 6'h00;
    repeat (4) @(posedge pclk);
    accept <= 1'b0;
    lag <= 4'h0;
    port_in_l1 <= 6'h02;
    l1_wait(2'b01);
    $display("L1 test done");
    port_dl_up <= 6'h01;
    port_tlp_seen <= 6'h04;
    @(posedge pclk);
    port_tlp_seen <= 6'h00;
    repeat (30) @(posedge pclk);
    chk(port_link_up_indicator_n_ff, 6'h3E);
    chk(port_activity_indicator_n_ff, 6'h3B);
    port_tlp_seen <= 6'h04;
    @(posedge pclk);
    port_tlp_seen <= 6'h00;
    repeat (45) @(posedge pclk);
    chk(port_activity_indicator_n_ff, 6'h3B);
    repeat (30) @(posedge pclk);
    chk(port_activity_indicator_n_ff, 6'h3F);
    $display("indicator test done");
    port_rate_5g <= 6'h03;
    wr(`PPLC_OFF_LINK_CTL2, 32'h0000_3F38);
    recov(1'b0);
    chk(tx_deemph_6db_ff, 6'h02);
    chk(up_adv_deemph_6db_ff, 1'b1);
    recov(1'b1);
    chk(tx_deemph_6db_ff, 6'h03);
    // Compliance on port 0 takes its own field; port 1 drops to 2.5 Gbps
    port_in_compliance <= 6'h01;
    port_rate_5g <= 6'h01;
    repeat (2) @(posedge pclk);
    chk(tx_deemph_6db_ff, 6'h00);
    port_in_compliance <= 6'h00;
    port_rate_5g <= 6'h03;
    recov(1'b1);
    wr(`PPLC_OFF_SER_CTL, 32'h0000_0002);
    repeat (2) @(posedge pclk);
    chk({tx_low_swing_ff, tx_deemph_off_ff[1], tx_deemph_6db_ff}, 13'h0141);
    apb(1'b0, `PPLC_OFF_LINK_STS2, 32'h0);
    chk(q[13:8], 6'h3D);
    chk(q[5:0], 6'h3C);
    $display("de-emphasis test done");
    presetn <= 1'b0;
    switch_operating_mode <= 3'h4;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    repeat (3) @(posedge pclk);
    chk(crosslink_en_ff, 6'h3F);
    rd(`PPLC_OFF_PHY_CFG, 32'h0000_0000);
    $display("crosslink test done");
    stop_test();
  end
endmodule

bind pplc_top pplc_checker #(.ACT_HOLD_CYC(ACT_HOLD_CYC)) u_pplc_checker (
  .pclk, .presetn, .psel, .penable, .pready_ff, .pslverr_ff, .port_dl_up,
  .port_dev_d3, .port_rx_l0s, .port_in_l1, .port_dllp_pend, .port_rate_5g,
  .port_tlp_seen, .up_l1_ack, .up_l1_nak, .port_l0s_req_ff, .up_l1_req_ff,
  .up_l1_enter_ff, .up_l0s_fallback_ff, .port_link_up_indicator_n_ff,
  .port_activity_indicator_n_ff, .tx_deemph_6db_ff, .tx_deemph_off_ff, .tx_low_swing_ff);
`default_nettype wire
